// >>> src/spiq_params.svh
// Register indices, field positions, reset values and timing counts of the serial port block
`ifndef SPIQ_PARAMS_SVH
`define SPIQ_PARAMS_SVH

// Register indices; byte address is four times the index
`define SPIQ_IDX_STATUS   14'h00FE
`define SPIQ_IDX_DATA     14'h00FF
`define SPIQ_IDX_TX_BASE  14'h2057
`define SPIQ_IDX_RX_BASE  14'h2058
`define SPIQ_IDX_CNT_LO   14'h2059
`define SPIQ_IDX_CNT_HI   14'h205A
`define SPIQ_IDX_MCLK_SEL 14'h205B
`define SPIQ_IDX_PAD_FAST 14'h205F
`define SPIQ_IDX_CTRL     14'h2060
`define SPIQ_IDX_IRQ_STAT 14'h2061
`define SPIQ_IDX_IRQ_EN   14'h2062
`define SPIQ_IDX_IRQ_CLR  14'h2063

// Status register fields
`define SPIQ_ST_TX_EMPTY  0
`define SPIQ_ST_OVF       1
`define SPIQ_ST_RX_FULL   2

// Control register fields
`define SPIQ_CT_ENABLE    0
`define SPIQ_CT_MASTER    1
`define SPIQ_CT_GO        2

// Interrupt status, enable and clear fields
`define SPIQ_IRQ_TX_EMPTY 0
`define SPIQ_IRQ_RX_FULL  1
`define SPIQ_IRQ_FAST     2
`define SPIQ_IRQ_W        3

// Reset values
`define SPIQ_STATUS_RST   8'h01
`define SPIQ_REG_RST      8'h00

// Timing: master serial clock half period
`define SPIQ_CLK_NS       50
`define SPIQ_HALF_NS      500
`define SPIQ_HALF_CYC     ((`SPIQ_HALF_NS + `SPIQ_CLK_NS - 1) / `SPIQ_CLK_NS)

`endif

// >>> src/spiq_pkg.sv
// Types shared by the serial port register block
package spiq_pkg;

	// High-speed buffer mover states
	typedef enum logic [1:0] {
		FAST_IDLE,
		FAST_FETCH,
		FAST_SHIFT,
		FAST_STORE
	} spiq_fast_e;

	// Whole state of the register block
	typedef struct packed {
		logic             enable;
		logic             master;
		logic             go;
		logic             rx_full;
		logic             ovf;
		logic             tx_empty;
		logic             status_seen;
		logic [7:0]       rx_buf;
		logic [7:0]       tx_buf;
		logic [7:0]       tx_base;
		logic [7:0]       rx_base;
		logic [7:0]       cnt_lo;
		logic [2:0]       cnt_hi;
		logic             mclk_sel;
		logic [5:0]       pad_fast;
		logic [2:0]       irq_st;
		logic [2:0]       irq_en;
		logic [7:0]       prdata;
		logic             perr;
		logic [7:0]       sh;
		logic [7:0]       rx_sh;
		logic             loaded;
		logic [3:0]       bitn;
		logic [7:0]       div;
		logic             sclk;
		logic             pad_prev;
		logic [10:0]      idx;
		spiq_fast_e       fst;
		logic             mem_req;
		logic             mem_we;
		logic [11:0]      mem_addr;
		logic [7:0]       mem_wdata;
	} spiq_state_s;

	// Synchroniser state
	typedef struct packed {
		logic [2:0] meta;
		logic [2:0] sync;
	} spiq_sync_s;

endpackage

// >>> src/spiq_sync.sv
// Two-stage synchroniser for the serial pins
`timescale 1ns/1ps

module spiq_sync (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	// Pins from outside the clock domain
	input  wire logic [2:0] i_async,
	// Synchronised copies
	output logic      [2:0] o_sync
);

	spiq_pkg::spiq_sync_s st_ff;   // Both stages
	spiq_pkg::spiq_sync_s nxt_st;  // Next value

	// First stage feeds only the second stage
	always_comb begin
		nxt_st      = st_ff;
		nxt_st.meta = i_async;
		nxt_st.sync = st_ff.meta;
	end

	// Stages register on every rising edge
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_sync = st_ff.sync;

endmodule

// >>> src/spiq_regs.sv
// Serial port status, data and high-speed buffer registers with APB access
`timescale 1ns/1ps
`include "spiq_params.svh"
// Operation
// - Receive-full set on data, write 0 clears
// - Normal mode overflow is flag only
// - Fast mode ends at count, sets full
// - Transmit-empty resets high, data write into the busy buffer clears
// - Idle first byte to shifter, second buffered
// - Data read gives receive buffer, write loads
// - Unread buffer: overflow set, new byte dropped
// - Data writes ignored while module disabled
// - Status read then data read clears full
// - Master mode data write starts transfer
// - Fast transmit address is base times eight
// - Fast receive address is base times eight
// - Fast count is three high, eight low
// - Receive clock select: internal or pad
// - Six pad bits select fast pad mode
// - Fast start bit clears when finished

module spiq_regs #(
	parameter int HALF_CYC = `SPIQ_HALF_CYC  // Master clock half period in cycles
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [15:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Interrupt
	output logic             o_irq,
	// Serial pins
	input  wire logic        i_sclk,
	input  wire logic        i_sdi,
	input  wire logic        i_cs_n,
	output logic             o_sclk,
	output logic             o_sclk_oe,
	output logic             o_sdo,
	output logic             o_sdo_oe,
	// Pad speed selects
	output logic      [5:0]  o_pad_fast,
	// Buffer memory port
	output logic             o_mem_req,
	output logic             o_mem_we,
	output logic      [11:0] o_mem_addr,
	output logic      [7:0]  o_mem_wdata,
	input  wire logic [7:0]  i_mem_rdata,
	input  wire logic        i_mem_ack
);

	spiq_pkg::spiq_state_s st_ff;   // Registered state
	spiq_pkg::spiq_state_s nxt_st;  // Next state

	logic [2:0]  pins_s;       // Synchronised cs_n, sdi, sclk
	logic        s_sclk;       // Pad clock after sync
	logic        s_sdi;        // Serial data after sync
	logic        s_cs_n;       // Select after sync
	logic        setup;        // APB setup cycle
	logic        wr;           // Completed APB write
	logic        rd;           // Completed APB read
	logic [13:0] ridx;         // Register index
	logic [7:0]  wdat;         // Write data, low byte
	logic        sel_act;      // Slave selected
	logic        pad_rise;     // Pad clock rising
	logic        pad_fall;     // Pad clock falling
	logic        tick;         // Master half period elapsed
	logic        smp;          // Sample receive bit
	logic        shf;          // Shift transmit bit
	logic        done;         // Byte finished
	logic [7:0]  rx_val;       // Byte just received
	logic [7:0]  byte_in;      // Byte handed over when a byte is done
	logic [10:0] fast_cnt;     // Configured fast count
	logic [2:0]  ev;           // Interrupt events this cycle

	// Every pin from outside passes two flops
	spiq_sync u_sync (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_async ({i_cs_n, i_sdi, i_sclk}),
		.o_sync  (pins_s)
	);

	assign s_sclk = pins_s[0];
	assign s_sdi  = pins_s[1];
	assign s_cs_n = pins_s[2];

	// APB phase decode
	assign setup = i_psel & ~i_penable;
	assign wr    = i_psel & i_penable & i_pwrite & ~st_ff.perr;
	assign rd    = i_psel & i_penable & ~i_pwrite & ~st_ff.perr;
	assign ridx  = i_paddr[15:2];
	assign wdat  = i_pwdata[7:0];

	// Serial edge detection on the synchronised pad clock
	assign sel_act  = ~st_ff.master & ~s_cs_n;
	assign pad_rise = s_sclk & ~st_ff.pad_prev;
	assign pad_fall = ~s_sclk & st_ff.pad_prev;
	assign tick     = st_ff.master & st_ff.loaded & (st_ff.div == 8'(HALF_CYC - 1));

	// Sample edge source depends on role and clock select
	always_comb begin
		if (st_ff.master) begin
			smp = st_ff.loaded & (st_ff.mclk_sel ? (tick & ~st_ff.sclk) : pad_rise);
			shf = tick & st_ff.sclk;
		end else begin
			smp = pad_rise & sel_act;
			shf = pad_fall & sel_act;
		end
	end

	// Master ends a byte on its eighth falling edge, so the last pulse keeps full length
	assign done     = st_ff.master ? (shf & (st_ff.bitn == 4'h8)) : (smp & (st_ff.bitn == 4'h7));
	assign rx_val   = {st_ff.rx_sh[6:0], s_sdi};
	// Master already holds all eight samples; slave completes on its last sample
	assign byte_in  = st_ff.master ? st_ff.rx_sh : rx_val;
	assign fast_cnt = {st_ff.cnt_hi, st_ff.cnt_lo};

	// Next state: bus first, then hardware, so hardware sets win
	always_comb begin
		nxt_st          = st_ff;
		ev              = '0;
		nxt_st.pad_prev = s_sclk;

		// Setup cycle: latch read data and decode error
		if (setup) begin
			nxt_st.perr   = 1'b0;
			nxt_st.prdata = '0;
			unique case (ridx)
				`SPIQ_IDX_STATUS:   nxt_st.prdata = {5'h00, st_ff.rx_full, st_ff.ovf,
					st_ff.tx_empty};
				`SPIQ_IDX_DATA:     nxt_st.prdata = st_ff.rx_buf;
				`SPIQ_IDX_TX_BASE:  nxt_st.prdata = st_ff.tx_base;
				`SPIQ_IDX_RX_BASE:  nxt_st.prdata = st_ff.rx_base;
				`SPIQ_IDX_CNT_LO:   nxt_st.prdata = st_ff.cnt_lo;
				`SPIQ_IDX_CNT_HI:   nxt_st.prdata = {5'h00, st_ff.cnt_hi};
				`SPIQ_IDX_MCLK_SEL: nxt_st.prdata = {7'h00, st_ff.mclk_sel};
				`SPIQ_IDX_PAD_FAST: nxt_st.prdata = {2'h0, st_ff.pad_fast};
				`SPIQ_IDX_CTRL:     nxt_st.prdata = {5'h00, st_ff.go, st_ff.master,
					st_ff.enable};
				`SPIQ_IDX_IRQ_STAT: nxt_st.prdata = {5'h00, st_ff.irq_st};
				`SPIQ_IDX_IRQ_EN:   nxt_st.prdata = {5'h00, st_ff.irq_en};
				`SPIQ_IDX_IRQ_CLR:  nxt_st.prdata = 8'h00;
				// Unmapped or misaligned address answers with an error
				default:            nxt_st.perr = 1'b1;
			endcase
			if (i_paddr[1:0] != 2'h0) begin
				nxt_st.perr = 1'b1;
			end
		end

		// Register writes
		if (wr) begin
			unique case (ridx)
				`SPIQ_IDX_STATUS: begin
					// Zero written clears; transmit-empty is hardware owned
					if (!wdat[`SPIQ_ST_RX_FULL]) begin
						nxt_st.rx_full = 1'b0;
					end
					if (!wdat[`SPIQ_ST_OVF]) begin
						nxt_st.ovf = 1'b0;
					end
				end
				`SPIQ_IDX_DATA: begin
					if (st_ff.enable && !st_ff.go) begin
						if (!st_ff.loaded) begin
							// Idle: straight into the shifter, starts a master transfer
							nxt_st.sh     = wdat;
							nxt_st.loaded = 1'b1;
							nxt_st.div    = '0;
							nxt_st.sclk   = 1'b0;
						end else begin
							// Busy: queue it, buffer now full
							nxt_st.tx_buf   = wdat;
							nxt_st.tx_empty = 1'b0;
						end
					end
				end
				`SPIQ_IDX_TX_BASE:  nxt_st.tx_base  = wdat;
				`SPIQ_IDX_RX_BASE:  nxt_st.rx_base  = wdat;
				`SPIQ_IDX_CNT_LO:   nxt_st.cnt_lo   = wdat;
				`SPIQ_IDX_CNT_HI:   nxt_st.cnt_hi   = wdat[2:0];
				`SPIQ_IDX_MCLK_SEL: nxt_st.mclk_sel = wdat[0];
				`SPIQ_IDX_PAD_FAST: nxt_st.pad_fast = wdat[5:0];
				`SPIQ_IDX_CTRL: begin
					nxt_st.enable = wdat[`SPIQ_CT_ENABLE];
					nxt_st.master = wdat[`SPIQ_CT_MASTER];
					// Start only from rest; a zero write cannot abort a run
					if (wdat[`SPIQ_CT_GO] && wdat[`SPIQ_CT_ENABLE] && !st_ff.go &&
						!st_ff.loaded) begin
						nxt_st.idx = '0;
						if (fast_cnt == 11'h000) begin
							nxt_st.rx_full = 1'b1;
							ev[`SPIQ_IRQ_RX_FULL] = 1'b1;
							ev[`SPIQ_IRQ_FAST]    = 1'b1;
						end else begin
							nxt_st.go       = 1'b1;
							nxt_st.fst      = spiq_pkg::FAST_FETCH;
							nxt_st.mem_req  = 1'b1;
							nxt_st.mem_we   = 1'b0;
							nxt_st.mem_addr = {1'b0, st_ff.tx_base, 3'h0};
						end
					end
				end
				`SPIQ_IDX_IRQ_EN:   nxt_st.irq_en = wdat[2:0];
				`SPIQ_IDX_IRQ_CLR:  nxt_st.irq_st = st_ff.irq_st & ~wdat[2:0];
				default: begin
					// Read-only status takes no write
				end
			endcase
		end

		// Register reads with side effects
		if (rd && ridx == `SPIQ_IDX_STATUS) begin
			nxt_st.status_seen = st_ff.rx_full;
		end
		if (rd && ridx == `SPIQ_IDX_DATA) begin
			// Only a status read that saw full arms this clear
			if (st_ff.status_seen) begin
				nxt_st.rx_full = 1'b0;
			end
			nxt_st.status_seen = 1'b0;
		end

		// Master clock divider runs only with a loaded shifter
		if (st_ff.master && st_ff.loaded) begin
			if (tick) begin
				nxt_st.div  = '0;
				nxt_st.sclk = ~st_ff.sclk;
			end else begin
				nxt_st.div = st_ff.div + 8'h01;
			end
		end

		// Slave deselect abandons a partial byte
		if (!st_ff.master && s_cs_n) begin
			nxt_st.bitn = '0;
		end

		// Shift out on the trailing edge
		if (shf) begin
			nxt_st.sh = {st_ff.sh[6:0], 1'b0};
		end

		// Sample in on the leading edge
		if (smp) begin
			nxt_st.rx_sh = rx_val;
			nxt_st.bitn  = st_ff.bitn + 4'h1;
		end

		// Byte complete
		if (done) begin
			nxt_st.bitn   = '0;
			nxt_st.loaded = 1'b0;
			nxt_st.sclk   = 1'b0;
			nxt_st.div    = '0;
			if (st_ff.go) begin
				// Fast mode: write the byte out; overflow never applies
				nxt_st.fst       = spiq_pkg::FAST_STORE;
				nxt_st.mem_req   = 1'b1;
				nxt_st.mem_we    = 1'b1;
				nxt_st.mem_addr  = {1'b0, st_ff.rx_base, 3'h0} + {1'b0, st_ff.idx};
				nxt_st.mem_wdata = byte_in;
			end else begin
				if (nxt_st.rx_full) begin
					// Old byte still unread: keep it, drop the new one
					nxt_st.ovf = 1'b1;
				end else begin
					nxt_st.rx_buf  = byte_in;
					nxt_st.rx_full = 1'b1;
					ev[`SPIQ_IRQ_RX_FULL] = 1'b1;
				end
				// Queued byte follows at once; a write in this same cycle counts too
				if (!nxt_st.tx_empty) begin
					nxt_st.sh       = nxt_st.tx_buf;
					nxt_st.loaded   = 1'b1;
					nxt_st.tx_empty = 1'b1;
					ev[`SPIQ_IRQ_TX_EMPTY] = 1'b1;
				end
			end
		end

		// Fast buffer mover
		unique case (st_ff.fst)
			spiq_pkg::FAST_IDLE: begin
				// Waiting for a start
			end
			spiq_pkg::FAST_FETCH: begin
				if (i_mem_ack) begin
					nxt_st.mem_req = 1'b0;
					nxt_st.sh      = i_mem_rdata;
					nxt_st.loaded  = 1'b1;
					nxt_st.div     = '0;
					nxt_st.sclk    = 1'b0;
					nxt_st.fst     = spiq_pkg::FAST_SHIFT;
				end
			end
			spiq_pkg::FAST_SHIFT: begin
				// Byte done handling moves on to the store
			end
			spiq_pkg::FAST_STORE: begin
				if (i_mem_ack) begin
					nxt_st.mem_req = 1'b0;
					nxt_st.mem_we  = 1'b0;
					nxt_st.idx     = st_ff.idx + 11'h001;
					if (st_ff.idx + 11'h001 == fast_cnt) begin
						nxt_st.go      = 1'b0;
						nxt_st.fst     = spiq_pkg::FAST_IDLE;
						nxt_st.rx_full = 1'b1;
						ev[`SPIQ_IRQ_RX_FULL] = 1'b1;
						ev[`SPIQ_IRQ_FAST]    = 1'b1;
					end else begin
						nxt_st.fst      = spiq_pkg::FAST_FETCH;
						nxt_st.mem_req  = 1'b1;
						nxt_st.mem_addr = {1'b0, st_ff.tx_base, 3'h0} +
							{1'b0, st_ff.idx + 11'h001};
					end
				end
			end
		endcase

		// Events set sticky bits after any clear, so a set wins
		nxt_st.irq_st = nxt_st.irq_st | ev;
	end

	// State register; reset takes constants only
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			st_ff          <= '0;
			st_ff.tx_empty <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// APB answers: data latched at setup, so no wait state is needed
	assign o_prdata  = {24'h000000, st_ff.prdata};
	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel & i_penable & st_ff.perr;

	// Level interrupt from enabled sticky bits
	assign o_irq = |(st_ff.irq_st & st_ff.irq_en);

	// Serial pins
	assign o_sclk     = st_ff.sclk;
	assign o_sclk_oe  = st_ff.master & st_ff.enable;
	assign o_sdo      = st_ff.sh[7];
	assign o_sdo_oe   = st_ff.enable & (st_ff.master | sel_act);
	assign o_pad_fast = st_ff.pad_fast;

	// Buffer memory port
	assign o_mem_req   = st_ff.mem_req;
	assign o_mem_we    = st_ff.mem_we;
	assign o_mem_addr  = st_ff.mem_addr;
	assign o_mem_wdata = st_ff.mem_wdata;

endmodule

// >>> tb/spiq_chk.sv
// Port-level assertions for the serial port register block
`timescale 1ns/1ps

module spiq_chk #(
	parameter int HALF_CYC = 4  // Master clock half period in cycles
) (
	// Clock, reset and bus
	input wire logic        i_clk,
	input wire logic        i_reset,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	// Serial side and pads
	input wire logic        o_sclk,
	input wire logic        o_sclk_oe,
	input wire logic        o_sdo,
	input wire logic        o_sdo_oe,
	input wire logic [5:0]  o_pad_fast,
	// Buffer memory port
	input wire logic        o_mem_req,
	input wire logic        o_mem_we,
	input wire logic [11:0] o_mem_addr,
	input wire logic [7:0]  o_mem_wdata,
	input wire logic        i_mem_ack
);
	// Cycles the master clock has been high; a wrong divider shows here
	logic [7:0] hi_ff;

	// Count high cycles, restart whenever the clock is low
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset)
			hi_ff <= 8'h00;
		else
			hi_ff <= o_sclk ? hi_ff + 8'h01 : 8'h00;
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	chk_apb_ready: assert property (i_psel && i_penable |-> o_pready)
		else $error("access phase without ready");
	chk_rdata_hold: assert property ($changed(o_prdata) |-> $past(i_psel && !i_penable))
		else $error("read data moved outside a setup");
	chk_rdata_upper: assert property (o_prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_half_period: assert property ($fell(o_sclk) |-> hi_ff == HALF_CYC)
		else $error("master clock high time wrong");
	chk_sdo_on_low: assert property ($changed(o_sdo) && o_sdo_oe |-> !o_sclk)
		else $error("data out moved while clock high");
	chk_sclk_driven: assert property (o_sclk |-> o_sclk_oe && o_sdo_oe)
		else $error("clock toggles without drive");
	chk_pad_by_write: assert property ($changed(o_pad_fast) |-> $past(i_psel && i_pwrite))
		else $error("pad selects moved without a write");
	chk_mem_hold: assert property (o_mem_req && !i_mem_ack |=> o_mem_req &&
		$stable(o_mem_addr) && $stable(o_mem_we) && $stable(o_mem_wdata))
		else $error("memory request dropped before ack");
endmodule

// >>> tb/spiq_peer.sv
// Serial slave on the far side of the master link
`timescale 1ns/1ps

module spiq_peer (
	// Link from the master
	input  wire logic       i_sclk,
	input  wire logic       i_mosi,
	input  wire logic       i_drive,
	// Reply line and progress
	output logic            o_miso,
	output logic      [7:0] o_got,
	output logic      [7:0] o_cnt
);
	logic [7:0] rx;               // Bits gathered so far
	logic [2:0] bn = 3'h0;        // Bit position in the byte
	logic       bq = 1'b1;        // Reply bit; byte n replies C3 xor n
	wire  [7:0] rep = 8'hC3 ^ o_cnt;

	initial begin
		o_got = 8'h00;
		o_cnt = 8'h00;
	end

	// Mode 0, MSB first: sample on the rising edge
	always @(posedge i_sclk) begin
		rx <= {rx[6:0], i_mosi};
		bn <= bn + 3'h1;
		if (bn == 3'h7) begin
			o_got <= {rx[6:0], i_mosi};
			o_cnt <= o_cnt + 8'h01;
		end
	end

	// Next bit goes out on the falling edge
	always @(negedge i_sclk)
		bq <= rep[3'h7 - bn];

	// An undriven link does not keep its last level
	assign o_miso = i_drive ? bq : ~bq;
endmodule

// >>> tb/spiq_regs_tb.sv
// Self-checking bench for the serial port register block
`timescale 1ns/1ps
`include "spiq_params.svh"

module spiq_regs_tb;
	localparam int HALF = 4;  // Gives a 400 ns link clock
	localparam int TXB = 3;
	localparam int RXB = 100;
	localparam logic [13:0] ST = `SPIQ_IDX_STATUS, DT = `SPIQ_IDX_DATA;
	// Design inputs
	logic        i_clk = 1'b0;
	logic        i_reset = 1'b1;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [15:0] pa = 16'h0000;
	logic [31:0] pwd = 32'h0;
	logic [7:0]  mrd = 8'h00;
	logic        mack = 1'b0;
	// Design outputs and bench state
	logic [31:0] prd;
	logic        prdy, perr, irq, sclk, soe, sdo, doe, miso, mreq, mwe;
	logic [5:0]  pad;
	logic [11:0] ma;
	logic [7:0]  mwd, got, cnt, v, n0;
	logic [32:0] q[$];
	int          n_errors = 0;
	int          checks = 0;
	int          wi = 0;
	int          ri = 0;
	logic [13:0] ri_t[6] = '{`SPIQ_IDX_TX_BASE, `SPIQ_IDX_RX_BASE, `SPIQ_IDX_CNT_LO,
		`SPIQ_IDX_CNT_HI, `SPIQ_IDX_MCLK_SEL, `SPIQ_IDX_PAD_FAST};
	logic [7:0]  rm_t[6] = '{8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h01, 8'h3F};

	spiq_regs #(.HALF_CYC(HALF)) uut (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
		.o_pready(prdy), .o_pslverr(perr), .o_irq(irq), .i_sclk(sclk), .i_sdi(miso),
		.i_cs_n(1'b1), .o_sclk(sclk), .o_sclk_oe(soe), .o_sdo(sdo), .o_sdo_oe(doe),
		.o_pad_fast(pad), .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_addr(ma),
		.o_mem_wdata(mwd), .i_mem_rdata(mrd), .i_mem_ack(mack));
	// Pad clock looped back, as the receive clock select expects
	spiq_peer peer (.i_sclk(sclk), .i_mosi(sdo), .i_drive(doe), .o_miso(miso),
		.o_got(got), .o_cnt(cnt));

	initial forever #25 i_clk = ~i_clk;
	initial #5000000 end_sim(1);

	task automatic chk(input logic [32:0] s, input logic [32:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic end_sim(input int bad);
		n_errors += bad;
		if (n_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// One APB transfer; the note goes on the queue for the monitor
	task automatic apb(input logic [13:0] i, input logic w, input logic [7:0] d,
		input logic [32:0] e);
		int k;
		@(posedge i_clk);
		q.push_back(e);
		psel <= 1'b1;
		pwr <= w;
		pa <= {i, 2'b00};
		pwd <= {24'h0, d};
		@(posedge i_clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge i_clk);
			k++;
		end while (prdy !== 1'b1 && k < 16);
		if (prdy !== 1'b1)
			end_sim(1);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [13:0] i, input logic [7:0] d, input logic er = 1'b0);
		apb(i, 1'b1, d, {er, 32'h0});
	endtask
	task automatic rd(input logic [13:0] i, input logic [7:0] e);
		apb(i, 1'b0, 8'h00, {25'h0, e});
	endtask
	// Wait for the far side to see n more bytes, then the pin sync latency
	task automatic bytes(input int n);
		int k;
		for (k = 0; k < 2000 && cnt != 8'(n0 + n); k++)
			@(posedge i_clk);
		if (k == 2000)
			end_sim(1);
		cyc(8);
	endtask

	// Oldest note is compared when an access completes; writes check only the error
	always @(posedge i_clk) begin
		if (psel && pen && prdy && q.size() > 0) begin
			chk({perr, pwr ? 32'h0 : prd}, pwr ? {q[0][32], 32'h0} : q[0]);
			void'(q.pop_front());
		end
	end

	// Buffer memory answers one cycle after each request
	always @(posedge i_clk) begin
		mack <= 1'b0;
		if (mreq && !mack) begin
			mack <= 1'b1;
			mrd <= ma[7:0] ^ 8'h5A;
			if (mwe) begin
				chk(ma, RXB * 8 + wi);
				chk(mwd, 8'(n0 + wi) ^ 8'hC3);
				wi++;
			end else begin
				chk(ma, TXB * 8 + ri);
				ri++;
			end
		end
	end

	initial begin
		int k;
		int m;
		void'($urandom(38234));
		cyc(20);
		i_reset <= 1'b0;
		rd(ST, `SPIQ_STATUS_RST);
		rd(DT, 8'h00);
		for (k = 0; k < 6; k++)
			rd(ri_t[k], 8'h00);
		for (k = 0; k < 6; k++) begin
			v = 8'($urandom);
			wr(ri_t[k], v);
			rd(ri_t[k], v & rm_t[k]);
		end
		chk(pad, v & 8'h3F);
		wr(14'h0100, 8'h00, 1'b1);
		// Master but still disabled: a taken data write would start a transfer
		wr(`SPIQ_IDX_CTRL, 8'h02);
		wr(DT, 8'h5A);
		cyc(40);
		rd(ST, 8'h01);
		chk(cnt, 8'h00);
		// Two bytes back to back, pad clock then internal clock
		for (m = 0; m < 2; m++) begin
			n0 = cnt;
			wr(`SPIQ_IDX_MCLK_SEL, 8'(m));
			wr(`SPIQ_IDX_IRQ_EN, 8'(2 * m));
			wr(`SPIQ_IDX_CTRL, 8'h03);
			v = 8'($urandom);
			wr(DT, 8'($urandom));
			rd(ST, 8'h01);
			wr(DT, v);
			rd(ST, 8'h00);
			bytes(2);
			chk(got, v);
			rd(`SPIQ_IDX_IRQ_STAT, 8'h03);
			chk(irq, m);
			rd(ST, 8'h07);
			if (m == 1) begin
				wr(ST, 8'h00);
				rd(ST, 8'h01);
			end
			rd(DT, 8'hC3 ^ n0);
			if (m == 0) begin
				rd(ST, 8'h03);
				wr(ST, 8'h00);
				rd(ST, 8'h01);
			end
			wr(`SPIQ_IDX_IRQ_CLR, 8'h07);
			rd(`SPIQ_IDX_IRQ_STAT, 8'h00);
			chk(irq, 1'b0);
		end
		// Fast mode over 258 bytes, so the high count bits matter
		n0 = cnt;
		wr(`SPIQ_IDX_TX_BASE, 8'(TXB));
		wr(`SPIQ_IDX_RX_BASE, 8'(RXB));
		wr(`SPIQ_IDX_CNT_HI, 8'h01);
		wr(`SPIQ_IDX_CNT_LO, 8'h02);
		wr(`SPIQ_IDX_IRQ_EN, 8'h04);
		wr(`SPIQ_IDX_CTRL, 8'h07);
		for (k = 0; k < 40000 && wi < 258; k++)
			@(posedge i_clk);
		if (wi < 258)
			end_sim(1);
		rd(`SPIQ_IDX_CTRL, 8'h03);
		rd(ST, 8'h05);
		chk(irq, 1'b1);
		chk(ri, 258);
		chk(got, 8'(TXB * 8 + 257) ^ 8'h5A);
		end_sim(0);
	end
endmodule

bind spiq_regs spiq_chk #(.HALF_CYC(HALF_CYC)) u_chk (.i_clk(i_clk), .i_reset(i_reset),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .o_prdata(o_prdata),
	.o_pready(o_pready), .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe), .o_sdo(o_sdo),
	.o_sdo_oe(o_sdo_oe), .o_pad_fast(o_pad_fast), .o_mem_req(o_mem_req),
	.o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
	.i_mem_ack(i_mem_ack));
